// *** bcd_step.sv ***
// Two-digit BCD increment with a settable wrap point
module bcd_step (
  input wire logic [7:0] value,
  input wire logic [7:0] first,
  input wire logic [7:0] last,
  output logic [7:0] next,
  output logic wrap
);
  logic units_full;
  logic [3:0] units_inc;
  logic [3:0] tens_inc;
  logic [7:0] plain_inc;

  assign units_full = (value[3:0] == 4'h9);
  assign units_inc = units_full ? 4'h0 : value[3:0] + 4'h1;
  assign tens_inc = units_full ? value[7:4] + 4'h1 : value[7:4];
  assign plain_inc = {tens_inc, units_inc};
  assign wrap = (value == last);
  assign next = wrap ? first : plain_inc;
endmodule

// *** host_model.sv ***
// Host side of the register port, driven through its tasks
module host_model (
  input wire logic clk,
  output rtc_calendar_pkg::reg_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_calendar_pkg::*;

  initial req = '{wr: 1'b0, addr: 4'h0, wdata: 8'h00};

  // Callers may hand over any byte; bit 7 is cleared for address 7 only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a == 4'h7) d[7] = 1'b0;
    @(posedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    // Stale byte inverted after release so it cannot pass by luck
    req <= '{wr: 1'b0, addr: a, wdata: ~d};
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, addr: a, wdata: ~req.wdata};
    @(posedge clk);
  endtask
endmodule

// *** rtc_calendar_cfg.svh ***
// Constants of the calendar, trim and weekday-alarm time block
`ifndef RTC_CALENDAR_CFG_SVH
`define RTC_CALENDAR_CFG_SVH

`define OFS_DAY_OF_MONTH 4'h4
`define OFS_MONTH_CENTURY 4'h5
`define OFS_YEAR_COUNT 4'h6
`define OFS_SECOND_TRIM 4'h7
`define OFS_WKALARM_MINUTE 4'h8
`define OFS_WKALARM_HOUR 4'h9

`define CENTURY_BIT 7
`define TRIM_SIGN_BIT 6
`define MONTH_READ_MASK 8'h9f
`define DAY_READ_MASK 8'h3f
`define TRIM_READ_MASK 8'h7f
`define WKALARM_MINUTE_MASK 8'h7f
`define WKALARM_HOUR_MASK 8'h3f

`define SECOND_TRIM_RESET 7'h00
`define DAY_RESET 8'h01
`define MONTH_RESET 8'h01
`define YEAR_RESET 8'h00

`define OSC_HZ 32768
`define CLK_PERIOD_NS 40
`define NOMINAL_SECOND_COUNT 16'h8000
`define TRIM_STEP_CYCLES 16'h0002
`define TRIM_NEG_SPAN 16'h0080

`define FIRST_DAY 8'h01
`define FIRST_MONTH 8'h01
`define LAST_MONTH 8'h12
`define FIRST_YEAR 8'h00
`define LAST_YEAR 8'h99
`define LAST_DAY_LONG 8'h31
`define LAST_DAY_SHORT 8'h30
`define LAST_DAY_FEB_LEAP 8'h29
`define LAST_DAY_FEB 8'h28
`define MONTH_FEB 5'h02
`define MONTH_APR 5'h04
`define MONTH_JUN 5'h06
`define MONTH_SEP 5'h09
`define MONTH_NOV 5'h11
`define TRIM_SECOND_A 7'h00
`define TRIM_SECOND_B 7'h20
`define TRIM_SECOND_C 7'h40

`endif

// *** rtc_calendar_pkg.sv ***
// Types shared by the calendar block and its users
package rtc_calendar_pkg;

  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic century;
    logic [4:0] month;
    logic [7:0] year;
    logic [5:0] day;
  } calendar_t;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
  } alarm_time_t;

endpackage

// *** rtc_calendar_trim.sv ***
// Calendar counters, second divider trim and weekday-alarm time registers
`include "rtc_calendar_cfg.svh"

module rtc_calendar_trim (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire rtc_calendar_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic OSC_TICK,
  input wire logic [6:0] SECONDS_BCD,
  input wire logic DAY_INC,
  output logic SECOND_TICK,
  output rtc_calendar_pkg::calendar_t CALENDAR,
  output rtc_calendar_pkg::alarm_time_t WKALARM_TIME,
  output logic TRIM_ACTIVE
);
  import rtc_calendar_pkg::*;

  // Register state
  logic [7:0] day_reg;
  logic [7:0] day_next;
  logic [7:0] month_reg;
  logic [7:0] month_next;
  logic [7:0] year_reg;
  logic [7:0] year_next;
  logic century_reg;
  logic century_next;
  logic [6:0] trim_reg;
  logic [6:0] trim_next;
  logic trim_en_reg;
  logic trim_en_next;
  logic [6:0] wka_minute_reg;
  logic [6:0] wka_minute_next;
  logic [5:0] wka_hour_reg;
  logic [5:0] wka_hour_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Divider state
  logic [15:0] div_cnt_reg;
  logic [15:0] div_cnt_next;
  logic tick_reg;
  logic tick_next;
  logic wr_in_period_reg;
  logic wr_in_period_next;

  // Address match, shared by the write strobes and the read selection
  logic hit_day;
  logic hit_month;
  logic hit_year;
  logic hit_trim;
  logic hit_wka_minute;
  logic hit_wka_hour;

  assign hit_day = (REG_REQ.addr == `OFS_DAY_OF_MONTH);
  assign hit_month = (REG_REQ.addr == `OFS_MONTH_CENTURY);
  assign hit_year = (REG_REQ.addr == `OFS_YEAR_COUNT);
  assign hit_trim = (REG_REQ.addr == `OFS_SECOND_TRIM);
  assign hit_wka_minute = (REG_REQ.addr == `OFS_WKALARM_MINUTE);
  assign hit_wka_hour = (REG_REQ.addr == `OFS_WKALARM_HOUR);

  // Write decode
  logic wr_day;
  logic wr_month;
  logic wr_year;
  logic wr_trim;
  logic wr_wka_minute;
  logic wr_wka_hour;

  assign wr_day = REG_REQ.wr && hit_day;
  assign wr_month = REG_REQ.wr && hit_month;
  assign wr_year = REG_REQ.wr && hit_year;
  assign wr_trim = REG_REQ.wr && hit_trim;
  assign wr_wka_minute = REG_REQ.wr && hit_wka_minute;
  assign wr_wka_hour = REG_REQ.wr && hit_wka_hour;

  // Leap year: tens even with units 0/4/8, or tens odd with units 2/6
  logic tens_even;
  logic units_leap_even;
  logic units_leap_odd;
  logic leap_year;

  assign tens_even = ~year_reg[4];
  assign units_leap_even = (year_reg[3:0] == 4'h0) || (year_reg[3:0] == 4'h4) ||
                           (year_reg[3:0] == 4'h8);
  assign units_leap_odd = (year_reg[3:0] == 4'h2) || (year_reg[3:0] == 4'h6);
  assign leap_year = tens_even ? units_leap_even : units_leap_odd;

  // Last day of the current month
  logic [4:0] month_bcd;
  logic is_feb;
  logic is_short_month;
  logic [7:0] feb_last;
  logic [7:0] last_day;

  assign month_bcd = month_reg[4:0];
  assign is_feb = (month_bcd == `MONTH_FEB);
  assign is_short_month = (month_bcd == `MONTH_APR) || (month_bcd == `MONTH_JUN) ||
                          (month_bcd == `MONTH_SEP) || (month_bcd == `MONTH_NOV);
  assign feb_last = leap_year ? `LAST_DAY_FEB_LEAP : `LAST_DAY_FEB;
  assign last_day = is_feb ? feb_last :
                    is_short_month ? `LAST_DAY_SHORT : `LAST_DAY_LONG;

  // Carry chain, all combinational so every stage moves in one edge
  logic [7:0] day_inc_val;
  logic day_wrap;
  logic [7:0] month_inc_val;
  logic month_wrap;
  logic [7:0] year_inc_val;
  logic year_wrap;
  logic carry_month;
  logic carry_year;
  logic carry_century;

  bcd_step day_step (
    .value(day_reg),
    .first(`FIRST_DAY),
    .last(last_day),
    .next(day_inc_val),
    .wrap(day_wrap)
  );

  bcd_step month_step (
    .value(month_reg),
    .first(`FIRST_MONTH),
    .last(`LAST_MONTH),
    .next(month_inc_val),
    .wrap(month_wrap)
  );

  bcd_step year_step (
    .value(year_reg),
    .first(`FIRST_YEAR),
    .last(`LAST_YEAR),
    .next(year_inc_val),
    .wrap(year_wrap)
  );

  assign carry_month = DAY_INC && day_wrap;
  assign carry_year = carry_month && month_wrap;
  assign carry_century = carry_year && year_wrap;

  // Host write takes priority over a carry into the same register
  always_comb begin
    day_next = day_reg;
    if (wr_day) begin
      day_next = REG_REQ.wdata & `DAY_READ_MASK;
    end else if (DAY_INC) begin
      day_next = day_inc_val;
    end
  end

  always_comb begin
    month_next = month_reg;
    century_next = century_reg;
    if (wr_month) begin
      month_next = {3'h0, REG_REQ.wdata[4:0]};
      century_next = REG_REQ.wdata[`CENTURY_BIT];
    end else begin
      if (carry_month) begin
        month_next = month_inc_val;
      end
      if (carry_century) begin
        century_next = ~century_reg;
      end
    end
  end

  always_comb begin
    year_next = year_reg;
    if (wr_year) begin
      year_next = REG_REQ.wdata;
    end else if (carry_year) begin
      year_next = year_inc_val;
    end
  end

  // Trim value and its enable
  always_comb begin
    trim_next = trim_reg;
    trim_en_next = trim_en_reg;
    if (wr_trim) begin
      trim_next = REG_REQ.wdata[6:0];
      trim_en_next = 1'b1;
    end
  end

  // Weekday-alarm time registers only store; compare lives elsewhere
  assign wka_minute_next = wr_wka_minute ? REG_REQ.wdata[6:0] : wka_minute_reg;
  assign wka_hour_next = wr_wka_hour ? REG_REQ.wdata[5:0] : wka_hour_reg;

  // Trimmed period length
  logic trim_negative;
  logic [15:0] trim_wide;
  logic [15:0] len_pos;
  logic [15:0] len_neg;
  logic [15:0] len_trimmed;
  logic special_second;
  logic apply_trim;
  logic [15:0] period_len;

  assign trim_negative = trim_reg[`TRIM_SIGN_BIT];
  assign trim_wide = {9'h000, trim_reg};
  // Value zero still counts as trim once written: two cycles short
  // Positive: 32768 + 2*(v-1); value one leaves the period nominal
  assign len_pos = 16'(`NOMINAL_SECOND_COUNT + `TRIM_STEP_CYCLES * trim_wide
                       - `TRIM_STEP_CYCLES);
  // Negative: magnitude is 128 - v, removed twice
  assign len_neg = 16'(`NOMINAL_SECOND_COUNT
                       - `TRIM_STEP_CYCLES * (`TRIM_NEG_SPAN - trim_wide));
  assign len_trimmed = trim_negative ? len_neg : len_pos;
  assign special_second = (SECONDS_BCD == `TRIM_SECOND_A) ||
                          (SECONDS_BCD == `TRIM_SECOND_B) ||
                          (SECONDS_BCD == `TRIM_SECOND_C);
  // A write inside the period keeps it nominal until the next boundary
  assign apply_trim = trim_en_reg && special_second && !wr_in_period_reg;
  assign period_len = apply_trim ? len_trimmed : `NOMINAL_SECOND_COUNT;

  // Divider counts oscillator ticks; the tick itself passes untouched
  // Ending on count+1 >= length stays safe if the length shrinks mid-period
  logic div_end;

  assign div_end = OSC_TICK && (16'(div_cnt_reg + 16'h0001) >= period_len);

  always_comb begin
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (OSC_TICK) begin
      if (div_end) begin
        div_cnt_next = 16'h0000;
        tick_next = 1'b1;
      end else begin
        div_cnt_next = 16'(div_cnt_reg + 16'h0001);
      end
    end
  end

  // Set wins over the boundary clear, so a write at the edge skips a period
  always_comb begin
    wr_in_period_next = wr_in_period_reg;
    if (div_end) begin
      wr_in_period_next = 1'b0;
    end
    if (wr_trim) begin
      wr_in_period_next = 1'b1;
    end
  end

  // Read selection
  logic [7:0] rd_month;
  logic [7:0] rd_year;
  logic [7:0] rd_trim;
  logic [7:0] rd_wka_minute;
  logic [7:0] rd_wka_hour;
  logic [7:0] rd_day;

  assign rd_day = day_reg & `DAY_READ_MASK;
  assign rd_month = {century_reg, 2'h0, month_reg[4:0]} & `MONTH_READ_MASK;
  assign rd_year = year_reg;
  assign rd_trim = {1'b0, trim_reg} & `TRIM_READ_MASK;
  assign rd_wka_minute = {1'b0, wka_minute_reg} & `WKALARM_MINUTE_MASK;
  assign rd_wka_hour = {2'h0, wka_hour_reg} & `WKALARM_HOUR_MASK;

  // Unmapped addresses match nothing and read zero
  assign rdata_next = ({8{hit_day}} & rd_day) |
                      ({8{hit_month}} & rd_month) |
                      ({8{hit_year}} & rd_year) |
                      ({8{hit_trim}} & rd_trim) |
                      ({8{hit_wka_minute}} & rd_wka_minute) |
                      ({8{hit_wka_hour}} & rd_wka_hour);

  // Calendar flops; reset stands in for power-on detection
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      day_reg <= `DAY_RESET;
      month_reg <= `MONTH_RESET;
      year_reg <= `YEAR_RESET;
      century_reg <= 1'b0;
    end else begin
      day_reg <= day_next;
      month_reg <= month_next;
      year_reg <= year_next;
      century_reg <= century_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      trim_reg <= `SECOND_TRIM_RESET;
      trim_en_reg <= 1'b0;
    end else begin
      trim_reg <= trim_next;
      trim_en_reg <= trim_en_next;
    end
  end

  // Cleared only at a period end, so a write never trims its own period
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_in_period_reg <= 1'b0;
    end else begin
      wr_in_period_reg <= wr_in_period_next;
    end
  end

  // Alarm time has no documented reset value; zero keeps it defined
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wka_minute_reg <= 7'h00;
      wka_hour_reg <= 6'h00;
    end else begin
      wka_minute_reg <= wka_minute_next;
      wka_hour_reg <= wka_hour_next;
    end
  end

  // Divider count and the one-cycle second pulse
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      div_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Read data from a flop, so it stands a whole cycle whatever addr does next
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign SECOND_TICK = tick_reg;
  assign TRIM_ACTIVE = trim_en_reg;
  // Calendar fields leave from the flops, never from the carry chain
  assign CALENDAR.century = century_reg;
  assign CALENDAR.month = month_reg[4:0];
  assign CALENDAR.year = year_reg;
  assign CALENDAR.day = day_reg[5:0];
  // Bit 5 of the hour is PM in 12-hour mode, tens-twenty in 24-hour mode
  assign WKALARM_TIME.minute = wka_minute_reg;
  assign WKALARM_TIME.hour = wka_hour_reg;

endmodule

// *** rtc_calendar_trim_monitor.sv ***
// Assertions on the ports of the calendar, trim and alarm time block
module rtc_calendar_trim_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire rtc_calendar_pkg::reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic DAY_INC,
  input wire logic SECOND_TICK,
  input wire rtc_calendar_pkg::calendar_t CALENDAR,
  input wire rtc_calendar_pkg::alarm_time_t WKALARM_TIME,
  input wire logic TRIM_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_calendar_pkg::*;

  // Reads compared with the contents only when nothing changes them at the same edge
  wire logic idle = !REG_REQ.wr && !DAY_INC;
  wire logic carry = DAY_INC && !REG_REQ.wr;
  // Odd tens digit needs units 2 or 6, even tens 0, 4 or 8
  wire logic leap = CALENDAR.year[3:0] % 4 == (CALENDAR.year[4] ? 2 : 0);

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_month_read_pad:
  assert property (idle && REG_REQ.addr == 4'h5 |=>
    REG_RDATA == {CALENDAR.century, 2'b00, CALENDAR.month}) else $error("month read wrong");
  a_year_read_back:
  assert property (idle && REG_REQ.addr == 4'h6 |=> REG_RDATA == CALENDAR.year)
    else $error("year read wrong");
  a_trim_top_zero:
  assert property (REG_REQ.addr == 4'h7 |=> !REG_RDATA[7]) else $error("trim bit 7 set");
  a_alarm_minute_read:
  assert property (idle && REG_REQ.addr == 4'h8 |=> REG_RDATA == {1'b0, WKALARM_TIME.minute})
    else $error("alarm minute read wrong");
  a_alarm_hour_read:
  assert property (idle && REG_REQ.addr == 4'h9 |=> REG_RDATA == {2'b00, WKALARM_TIME.hour})
    else $error("alarm hour read wrong");
  a_day_end_wrap:
  assert property (carry && CALENDAR.day == 6'h31 |=>
    CALENDAR.day == 6'h01 && CALENDAR.month != $past(CALENDAR.month))
    else $error("day 31 did not wrap");
  a_feb_end_leap:
  assert property (carry && CALENDAR.month == 5'h02 && CALENDAR.day == 6'h28 |=>
    CALENDAR.day == ($past(leap) ? 6'h29 : 6'h01)) else $error("february end wrong");
  a_century_flip:
  assert property (carry && CALENDAR.month == 5'h12 && CALENDAR.day == 6'h31 &&
    CALENDAR.year == 8'h99 |=> CALENDAR.year == 8'h00 && CALENDAR.month == 5'h01 &&
    CALENDAR.century != $past(CALENDAR.century)) else $error("year end carry wrong");
  a_trim_write_arms:
  assert property (REG_REQ.wr && REG_REQ.addr == 4'h7 |=> TRIM_ACTIVE)
    else $error("trim not armed");
  a_tick_single:
  assert property (SECOND_TICK |=> !SECOND_TICK [*8]) else $error("second tick too long");
endmodule

bind rtc_calendar_trim rtc_calendar_trim_monitor rtc_calendar_trim_monitor_inst (
  .CLK(CLK), .RESET_N(RESET_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .DAY_INC(DAY_INC), .SECOND_TICK(SECOND_TICK), .CALENDAR(CALENDAR),
  .WKALARM_TIME(WKALARM_TIME), .TRIM_ACTIVE(TRIM_ACTIVE));

// *** rtc_calendar_trim_test.sv ***
// Self-checking bench for the calendar, trim and alarm time block
module rtc_calendar_trim_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_calendar_pkg::*;

  logic clk, reset_n, osc_tick, day_inc, second_tick, look;
  logic [6:0] seconds_bcd;
  logic [7:0] rdata, y;
  logic [4:0] m;
  logic [20:0] e;
  reg_req_t req;
  calendar_t cal;
  logic [20:0] exp_q[$];
  int per_q[$];
  int bad_count, n_tests, cnt;

  rtc_calendar_trim rtc_calendar_trim_inst (.CLK(clk), .RESET_N(reset_n), .REG_REQ(req),
    .REG_RDATA(rdata), .OSC_TICK(osc_tick), .SECONDS_BCD(seconds_bcd), .DAY_INC(day_inc),
    .SECOND_TICK(second_tick), .CALENDAR(cal), .WKALARM_TIME(), .TRIM_ACTIVE());
  host_model host_model_inst (.clk(clk), .req(req));

  always #20 clk = ~clk;

  task automatic conclude;
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
    if (m == 5'h02) return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 6'h29 : 6'h28;
    if (m inside {5'h04, 5'h06, 5'h09, 5'h11}) return 6'h30;
    return 6'h31;
  endfunction

  task automatic note(input logic [20:0] v);
    exp_q.push_back(v);
    look <= 1'b1;
    @(posedge clk) look <= 1'b0;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] v);
    host_model_inst.rd(a);
    note({13'h0000, v});
  endtask

  task automatic carry(input logic c, input logic [4:0] m, input logic [7:0] y,
                       input logic [5:0] d);
    calendar_t x;
    x = '{century: c, month: m, year: y, day: 6'(bcd_inc({2'b00, d}))};
    host_model_inst.wr(4'h4, {2'b00, d});
    host_model_inst.wr(4'h5, {c, 2'b00, m});
    host_model_inst.wr(4'h6, y);
    if (d == last_day(m, y)) begin
      x.day = 6'h01;
      x.month = (m == 5'h12) ? 5'h01 : 5'(bcd_inc({3'b000, m}));
      if (m == 5'h12) begin
        x.year = (y == 8'h99) ? 8'h00 : bcd_inc(y);
        x.century = c ^ (y == 8'h99);
      end
    end
    @(posedge clk) day_inc <= 1'b1;
    @(posedge clk) day_inc <= 1'b0;
    note({1'b1, x});
  endtask

  // Reads and carries land in one queue, checked in order
  always @(posedge clk) begin
    if (look) begin
      e = exp_q.pop_front();
      n_tests++;
      if (e[20] ? (cal !== e[19:0]) : (rdata !== e[7:0])) begin
        bad_count++;
        $display("unexpected at %0t: rdata %h cal %h want %h", $time, rdata, cal, e);
      end
    end
  end

  // Period length counted in oscillator ticks between second ticks
  always @(posedge clk) begin
    if (!reset_n) cnt <= 0;
    else if (second_tick) begin
      n_tests++;
      if (cnt !== per_q.pop_front()) begin
        bad_count++;
        $display("unexpected at %0t: second lasted %0d ticks", $time, cnt);
      end
      cnt <= int'(osc_tick);
    end else cnt <= cnt + int'(osc_tick);
  end

  initial begin
    // Three seconds of about 32768 cycles each, plus setup
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    osc_tick = 1'b0;
    day_inc = 1'b0;
    look = 1'b0;
    seconds_bcd = 7'h00;
    void'($urandom(32'h663f73a0));
    per_q = '{32768, 32780, 32768};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    osc_tick <= 1'b1;
    seconds_bcd <= 7'(8'h20 * $urandom_range(2));
    @(posedge clk);
    chk_rd(4'h7, 8'h00);
    host_model_inst.wr(4'h7, 8'h07);
    chk_rd(4'h7, 8'h07);
    host_model_inst.wr(4'h5, 8'he9);
    chk_rd(4'h5, 8'h89);
    host_model_inst.wr(4'h6, 8'h57);
    chk_rd(4'h6, 8'h57);
    y = {4'($urandom_range(5)), 4'($urandom_range(9))};
    host_model_inst.wr(4'h8, {1'b1, y[6:0]});
    chk_rd(4'h8, {1'b0, y[6:0]});
    host_model_inst.wr(4'h9, 8'he3);
    chk_rd(4'h9, 8'h23);
    // Unmapped place swallows the write
    host_model_inst.wr(4'h2, 8'hff);
    chk_rd(4'h2, 8'h00);
    for (int i = 1; i <= 12; i++) begin
      m = 5'((i > 9) ? i + 6 : i);
      y = {4'($urandom_range(9)), 4'($urandom_range(9))};
      carry(1'b0, m, y, last_day(m, y));
    end
    carry(1'b0, 5'h02, 8'h24, 6'h28);
    carry(1'b0, 5'h02, 8'h00, 6'h29);
    carry(1'b0, 5'h12, 8'h99, 6'h31);
    carry(1'b1, 5'h12, 8'h99, 6'h31);
    repeat (2) @(posedge second_tick);
    // Written inside the third period, so that period stays nominal
    host_model_inst.wr(4'h7, 8'h7e);
    chk_rd(4'h7, 8'h7e);
    @(posedge second_tick);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
